// ==== hdl/sd_adc.sv ====
`timescale 1ns/1ps
// Function
// - Each sampled comparator decision drives the integrator feedback pin.
// - Comparator input is the only analog bit, against a 1.2 V reference.
// - Keep a loop counter and a count of ones on the feedback output.
// - Input below reference: decrement balance, drive feedback high.
// - Input above reference: increment balance, drive feedback low.
// - Fifteen-bit result; one sample spans 32768 decisions.
// - Motion event comes from difference of consecutive results.
module sd_adc (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        CMP_BELOW,
   input  wire logic [14:0] DIFF_THRESH,
   output logic             FB_OUT,
   output logic [14:0]      RESULT,
   output logic             RESULT_VALID,
   output logic [15:0]      BALANCE,
   output logic             MOTION
);
   localparam logic [15:0] ONE16 = 16'h0001;

   logic        cmp_below;
   logic        fb_ff;
   logic [15:0] loop_ff;
   logic [15:0] ones_ff;
   logic [15:0] bal_ff;
   logic [14:0] result_ff;
   logic [14:0] prev_ff;
   logic        have_prev_ff;
   logic        valid_ff;
   logic        motion_ff;
   logic        terminal;
   logic [15:0] nxt_ones;
   logic [14:0] new_result;
   logic [14:0] diff;

   // Absolute difference of two results
   function automatic logic [14:0] abs_diff(input logic [14:0] a,
                                            input logic [14:0] b);
      abs_diff = (a >= b) ? (a - b) : (b - a);
   endfunction : abs_diff

   // Step of one up or down, shared by the loop, balance and gap counters
   function automatic logic [15:0] step_one(input logic [15:0] v,
                                            input logic        up);
      step_one = up ? (v + ONE16) : (v - ONE16);
   endfunction : step_one

   // Comparator is asynchronous to the system clock
   sd_sync u_sync (
      .SYS_CLK  (SYS_CLK),
      .RST      (RST),
      .ASYNC_IN (CMP_BELOW),
      .SYNC_OUT (cmp_below)
   );

   // Decode of terminal count and result
   assign terminal   = (loop_ff == sd_adc_pkg::LOOP_LAST);
   assign nxt_ones   = ones_ff + (fb_ff ? ONE16 : 16'h0000);
   // Full-scale 32768 ones saturates to the 15-bit maximum
   assign new_result = nxt_ones[15] ? 15'h7fff : nxt_ones[14:0];
   assign diff       = abs_diff(new_result, prev_ff);

   // Feedback drive follows the sampled decision
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         fb_ff <= 1'b0;
      end else begin
         fb_ff <= cmp_below;
      end
   end

   // Balance counter: down when charging, up when discharging
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         bal_ff <= sd_adc_pkg::LOOP_RST;
      end else if (terminal) begin
         bal_ff <= sd_adc_pkg::LOOP_RST;
      end else if (cmp_below) begin
         bal_ff <= step_one(bal_ff, 1'b0);
      end else begin
         bal_ff <= step_one(bal_ff, 1'b1);
      end
   end

   // Loop and ones counters
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         loop_ff <= sd_adc_pkg::LOOP_RST;
         ones_ff <= sd_adc_pkg::ONES_RST;
      end else if (terminal) begin
         loop_ff <= sd_adc_pkg::LOOP_RST;
         ones_ff <= sd_adc_pkg::ONES_RST;
      end else begin
         loop_ff <= step_one(loop_ff, 1'b1);
         ones_ff <= nxt_ones;
      end
   end

   // Result latch, strobe and motion compare
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         result_ff    <= sd_adc_pkg::RESULT_RST;
         prev_ff      <= sd_adc_pkg::RESULT_RST;
         have_prev_ff <= 1'b0;
         valid_ff     <= 1'b0;
         motion_ff    <= 1'b0;
      end else begin
         valid_ff  <= terminal;
         motion_ff <= terminal && have_prev_ff && (diff > DIFF_THRESH);
         if (terminal) begin
            result_ff    <= new_result;
            prev_ff      <= new_result;
            have_prev_ff <= 1'b1;
         end
      end
   end

   assign FB_OUT       = fb_ff;
   assign RESULT       = result_ff;
   assign RESULT_VALID = valid_ff;
   assign BALANCE      = bal_ff;
   assign MOTION       = motion_ff;

   // Checks
   // Cycles since the last result strobe, for the period check
   logic [15:0] gap_ff;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         gap_ff <= sd_adc_pkg::LOOP_RST;
      end else if (RESULT_VALID) begin
         gap_ff <= ONE16;
      end else begin
         gap_ff <= step_one(gap_ff, 1'b1);
      end
   end

   // Feedback is the decision of one clock earlier
   AST_FB_FOLLOWS: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      FB_OUT == $past(cmp_below))
      else $error("feedback does not follow comparator");

   // Strobe lasts a single clock
   AST_VALID_PULSE: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      RESULT_VALID |=> !RESULT_VALID)
      else $error("valid strobe longer than one clock");

   // Terminal count gives a strobe and a fresh loop
   AST_VALID_AT_TERM: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      terminal |=> RESULT_VALID && loop_ff == sd_adc_pkg::LOOP_RST)
      else $error("terminal count did not produce result");

   // Ones and balance restart from zero after terminal count
   AST_COUNT_CLEAR: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      terminal |=> ones_ff == sd_adc_pkg::ONES_RST
         && bal_ff == sd_adc_pkg::LOOP_RST)
      else $error("counters not cleared at terminal count");

   // Loop counter advances by one each decision except at terminal count
   AST_LOOP_STEP: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      !terminal |=> loop_ff == $past(loop_ff) + 16'h0001)
      else $error("loop counter did not step");

   // Strobes stand exactly one sample length apart
   AST_PERIOD: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      RESULT_VALID |-> gap_ff == 16'(sd_adc_pkg::SAMPLE_LEN))
      else $error("sample length is not 32768 decisions");

   // Below reference: count down and charge
   AST_BAL_DOWN: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      (cmp_below && !terminal) |=>
         bal_ff == $past(bal_ff) - 16'h0001 && FB_OUT)
      else $error("balance not decremented while charging");

   // Above reference: count up and discharge
   AST_BAL_UP: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      (!cmp_below && !terminal) |=>
         bal_ff == $past(bal_ff) + 16'h0001 && !FB_OUT)
      else $error("balance not incremented while discharging");

   // Ones count grows only on a high feedback cycle
   AST_ONES_STEP: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      !terminal |=>
         ones_ff == $past(ones_ff) + {15'h0000, $past(fb_ff)})
      else $error("ones count does not follow feedback");

   // Result only moves at terminal count
   AST_RESULT_HOLD: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      !terminal |=> $stable(RESULT))
      else $error("result changed outside terminal count");

   // Motion only comes with a new result
   AST_MOTION_VALID: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      MOTION |-> RESULT_VALID)
      else $error("motion without new result");

   // First result after reset has nothing to compare against
   AST_MOTION_PREV: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      MOTION |-> $past(have_prev_ff))
      else $error("motion flagged without previous result");

   // Motion needs a step above the threshold
   AST_MOTION_OVER: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      MOTION |-> abs_diff(RESULT, $past(prev_ff)) > DIFF_THRESH)
      else $error("motion flagged on a small step");

   // A large step between results never stays quiet
   AST_MOTION_UNDER: assert property (
      @(posedge SYS_CLK) disable iff (RST)
      RESULT_VALID && !MOTION && $past(have_prev_ff) |->
         abs_diff(RESULT, $past(prev_ff)) <= DIFF_THRESH)
      else $error("large step between results not flagged");

   // Main scenarios
   COV_RESULT: cover property (@(posedge SYS_CLK) disable iff (RST)
      RESULT_VALID);
   COV_MOTION: cover property (@(posedge SYS_CLK) disable iff (RST)
      MOTION);
   COV_QUIET: cover property (@(posedge SYS_CLK) disable iff (RST)
      RESULT_VALID && !MOTION && $past(have_prev_ff));
   COV_CHARGE: cover property (@(posedge SYS_CLK) disable iff (RST)
      FB_OUT ##1 !FB_OUT);
   COV_DISCHARGE: cover property (@(posedge SYS_CLK) disable iff (RST)
      !FB_OUT ##1 FB_OUT);
endmodule : sd_adc

// ==== hdl/sd_adc_pkg.sv ====
package sd_adc_pkg;
   // Conversion geometry
   localparam int unsigned RES_BITS    = 15;
   localparam int unsigned LOOP_BITS   = 16;
   localparam int unsigned SAMPLE_LEN  = 32768;
   localparam logic [LOOP_BITS-1:0] LOOP_LAST = 16'h7fff;
   localparam logic [LOOP_BITS-1:0] LOOP_RST  = 16'h0000;
   localparam logic [LOOP_BITS-1:0] ONES_RST  = 16'h0000;
   localparam logic [RES_BITS-1:0]  RESULT_RST = 15'h0000;
   // Reference level in millivolts, seen by the comparator
   localparam int unsigned REF_MV = 1200;
   // Motion threshold on the result difference
   localparam logic [RES_BITS-1:0] DIFF_THRESH_RST = 15'h0040;
   // Clock
   localparam int unsigned CLK_MHZ = 200;
endpackage : sd_adc_pkg

// ==== hdl/sd_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module sd_sync (
   input  wire logic SYS_CLK,
   input  wire logic RST,
   input  wire logic ASYNC_IN,
   output logic      SYNC_OUT
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic out_ff;

   // Shift chain
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s1_ff  <= 1'b0;
         s2_ff  <= 1'b0;
         s3_ff  <= 1'b0;
         out_ff <= 1'b0;
      end else begin
         s1_ff <= ASYNC_IN;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            out_ff <= s3_ff;
         end
      end
   end

   assign SYNC_OUT = out_ff;
endmodule : sd_sync

// ==== verif/sd_cmp_model.sv ====
`timescale 1ns/1ps
// Comparator with an RC integrator behind the feedback pin
module sd_cmp_model (
   input  wire logic clk,
   input  wire logic fb,
   input  wire logic forced,
   input  wire logic force_lvl,
   output logic      below
);
   int v = sd_adc_pkg::REF_MV;
   // Integrator charges on a high feedback, discharges on a low one
   always @(negedge clk) begin
      if (forced) begin
         v = sd_adc_pkg::REF_MV;
         below <= force_lvl;
      end else begin
         v = v + (fb ? 3 : -3);
         below <= (v < sd_adc_pkg::REF_MV);
      end
   end
endmodule : sd_cmp_model

// ==== verif/tb_sd_adc.sv ====
`timescale 1ns/1ps
module tb_sd_adc;
   typedef struct packed {logic [14:0] lo; logic [14:0] hi; logic mot;} note_s;
   logic        sys_clk, rst, forced, force_lvl, cmp_below;
   logic        fb_out, result_valid, motion, seen0, seen1;
   logic [14:0] diff_thresh, result;
   logic [15:0] balance, b0;
   note_s       notes[$];
   note_s       nt;
   int          err_total, n_compared, n_seen, i;
   sd_adc u_dut (.SYS_CLK(sys_clk), .RST(rst), .CMP_BELOW(cmp_below),
      .DIFF_THRESH(diff_thresh), .FB_OUT(fb_out), .RESULT(result),
      .RESULT_VALID(result_valid), .BALANCE(balance), .MOTION(motion));
   sd_cmp_model u_cmp (.clk(sys_clk), .fb(fb_out), .forced(forced),
      .force_lvl(force_lvl), .below(cmp_below));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask : check
   task results;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   // Oldest note is compared whenever a result appears
   always @(posedge sys_clk) begin
      #1;
      if (result_valid === 1'b1) begin
         n_seen++;
         if (notes.size() == 0) begin
            check("unexpected result", 16'h0, 16'h1);
         end else begin
            nt = notes.pop_front();
            check("result in range", 16'h1,
               {15'h0, (result >= nt.lo) && (result <= nt.hi)});
            check("motion", {15'h0, nt.mot}, {15'h0, motion});
         end
      end
   end
   task step(logic lvl);
      force_lvl <= lvl;
      repeat (20) @(negedge sys_clk);
      b0 = balance;
      repeat (8) @(negedge sys_clk);
      check("balance", lvl ? b0 - 16'h8 : b0 + 16'h8, balance);
      check("feedback", {15'h0, lvl}, {15'h0, fb_out});
   endtask : step
   task wait_result(int n);
      i = 0;
      while (n_seen < n && i < 33000) begin
         @(negedge sys_clk);
         i++;
      end
      if (n_seen < n) begin
         err_total++;
         results();
      end
   endtask : wait_result
   // Full-scale then zero-scale conversion, then the free-running loop
   initial begin
      void'($urandom(57));
      rst = 1'b1;
      forced = 1'b1;
      force_lvl = 1'b1;
      diff_thresh = 15'h0010 + 15'($urandom % 28672);
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      notes.push_back(note_s'{15'h7fe0, 15'h7fff, 1'b0});
      step(1'b1);
      wait_result(1);
      notes.push_back(note_s'{15'h0000, 15'h0010, 1'b1});
      step(1'b0);
      wait_result(2);
      // Second low-level sample: small step, no motion
      notes.push_back(note_s'{15'h0000, 15'h0010, 1'b0});
      wait_result(3);
      forced <= 1'b0;
      seen0 = 1'b0;
      seen1 = 1'b0;
      repeat (300) begin
         @(negedge sys_clk);
         seen0 |= (fb_out === 1'b0);
         seen1 |= (fb_out === 1'b1);
      end
      check("feedback toggles", 16'h3, {14'h0, seen1, seen0});
      results();
   end
endmodule : tb_sd_adc
